/* File: tb/draw_cmd_model.sv */
// Command processor and host model: drawing loads, register loads, host.
// Assumes the bench calls its tasks; drives on the falling clock edge.
`timescale 1ns/1ps
module draw_cmd_model (
    input  wire logic        clk_sys,
    output logic             draw_load,
    output logic [11:0]      draw_load_offset,
    output logic [31:0]      draw_load_data,
    output logic             reg_load,
    output logic [11:0]      reg_load_offset,
    output logic [31:0]      reg_load_data,
    output logic             cpu_req,
    output logic             cpu_write,
    output logic [7:0]       cpu_addr,
    output logic [31:0]      cpu_wdata
);
    // Idle values at time zero
    initial
    begin
        {draw_load, reg_load, cpu_req, cpu_write} = 4'h0;
        {draw_load_offset, reg_load_offset, cpu_addr} = 32'h0;
        {draw_load_data, reg_load_data, cpu_wdata} = 96'h0;
    end

    // One-cycle drawing load; released fields show the inverse, not stale
    task automatic cmd_draw(input logic [11:0] o, input logic [31:0] d);
        @(negedge clk_sys);
        draw_load = 1'b1;
        draw_load_offset = o;
        draw_load_data = d;
        @(negedge clk_sys);
        draw_load = 1'b0;
        draw_load_offset = ~o;
        draw_load_data = ~d;
    endtask : cmd_draw

    // Register-load command; only the key colour is meant for it
    task automatic cmd_reg(input logic [11:0] o, input logic [31:0] d);
        @(negedge clk_sys);
        reg_load = 1'b1;
        reg_load_offset = o;
        reg_load_data = d;
        @(negedge clk_sys);
        reg_load = 1'b0;
        reg_load_offset = ~o;
        reg_load_data = ~d;
    endtask : cmd_reg

    // Host request, one cycle; ack is due at the next falling edge
    task automatic host(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(negedge clk_sys);
        cpu_req = 1'b1;
        cpu_write = w;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge clk_sys);
        cpu_req = 1'b0;
        cpu_addr = ~a;
        cpu_wdata = ~d;
    endtask : host
endmodule : draw_cmd_model

/* File: tb/draw_param_bank_tb_top.sv */
// Self-checking bench for the drawing parameter bank and status word.
// Assumes draw_cmd_model for all request traffic; engine inputs driven here.
`timescale 1ns/1ps
module draw_param_bank_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        draw_load, reg_load, reg_load_refused, cpu_req, cpu_write;
    logic        cpu_ack, queue_push = 1'b0;
    logic        pixel_busy = 1'b0, setup_busy = 1'b0, setup_alt = 1'b0;
    logic        geometry_busy = 1'b0;
    logic [5:0]  queue_free = 6'h3F;
    logic [7:0]  cpu_addr, key_palette_code;
    logic [11:0] draw_load_offset, reg_load_offset;
    logic [31:0] draw_load_data, reg_load_data, cpu_wdata, cpu_rdata;
    logic [24:0] blit_source_address, blit_dest_address;
    logic [15:0] transparent_key_color;
    logic [11:0] blit_source_pitch, blit_source_x_start, blit_source_y_start;
    logic [11:0] blit_dest_pitch, blit_dest_x_start, blit_dest_y_start;
    logic [11:0] blit_width, blit_height, rect_left_x, rect_top_y;
    logic [11:0] rect_width, rect_height, fast_line_v0_x, fast_line_v0_y;
    logic [11:0] fast_line_v1_x, fast_line_v1_y, fast_tri_v0_x;
    logic [11:0] fast_tri_v0_y, fast_tri_v1_x, fast_tri_v1_y;
    logic [11:0] fast_tri_v2_x, fast_tri_v2_y;
    int          mismatches = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [31:0] d, prev;
    logic [5:0]  qf;
    localparam logic [11:0] OFS [24] = '{12'h200, 12'h204, 12'h208,
        12'h20C, 12'h240, 12'h244, 12'h248, 12'h24C, 12'h250, 12'h254,
        12'h258, 12'h25C, 12'h260, 12'h264, 12'h540, 12'h544, 12'h548,
        12'h54C, 12'h580, 12'h584, 12'h588, 12'h58C, 12'h590, 12'h594};

    draw_param_bank #(.QUEUE_STAGES(63)) i_draw_param_bank (.*);
    draw_cmd_model i_draw_cmd_model (.clk_sys(clk_sys),
        .draw_load(draw_load), .draw_load_offset(draw_load_offset),
        .draw_load_data(draw_load_data), .reg_load(reg_load),
        .reg_load_offset(reg_load_offset), .reg_load_data(reg_load_data),
        .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata));

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [31:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Engine-facing value held for an offset
    function automatic logic [31:0] seen(input logic [11:0] o);
        case (o)
            12'h200: return 32'(rect_left_x);
            12'h204: return 32'(rect_top_y);
            12'h208: return 32'(rect_width);
            12'h20C: return 32'(rect_height);
            12'h240: return 32'(blit_source_address);
            12'h244: return 32'(blit_source_pitch);
            12'h248: return 32'(blit_source_x_start);
            12'h24C: return 32'(blit_source_y_start);
            12'h250: return 32'(blit_dest_address);
            12'h254: return 32'(blit_dest_pitch);
            12'h258: return 32'(blit_dest_x_start);
            12'h25C: return 32'(blit_dest_y_start);
            12'h260: return 32'(blit_width);
            12'h264: return 32'(blit_height);
            12'h540: return 32'(fast_line_v0_x);
            12'h544: return 32'(fast_line_v0_y);
            12'h548: return 32'(fast_line_v1_x);
            12'h54C: return 32'(fast_line_v1_y);
            12'h580: return 32'(fast_tri_v0_x);
            12'h584: return 32'(fast_tri_v0_y);
            12'h588: return 32'(fast_tri_v1_x);
            12'h58C: return 32'(fast_tri_v1_y);
            12'h590: return 32'(fast_tri_v2_x);
            default: return 32'(fast_tri_v2_y);
        endcase
    endfunction : seen

    // Address fields keep 24:0, integer fields 27:16
    function automatic logic [31:0] exp_field(input logic [11:0] o,
                                              input logic [31:0] v);
        if (o == 12'h240 || o == 12'h250)
            return {7'h00, v[24:0]};
        return {20'h00000, v[27:16]};
    endfunction : exp_field

    function automatic logic [31:0] exp_stat(input logic ov);
        logic [31:0] w;
        w = 32'h0;
        w[1:0] = {1'b0, pixel_busy};
        w[5:4] = setup_busy ? (setup_alt ? 2'h2 : 2'h1) : 2'h0;
        w[9:8] = {1'b0, geometry_busy};
        w[12] = (queue_free == 6'h3F);
        w[13] = (queue_free == 6'h00);
        w[14] = (queue_free < 6'h1F);
        w[20:15] = queue_free;
        w[24] = ov;
        return w;
    endfunction : exp_stat

    // Host read of an offset after the inputs have settled
    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
        repeat (3) @(negedge clk_sys);
        i_draw_cmd_model.host(1'b0, a, 32'h0);
        chk("cpu_ack", 32'(cpu_ack), 32'h1);
        chk("cpu_rdata", cpu_rdata, exp);
    endtask : read_chk

    initial
    begin
        void'($urandom(32'h056FDD3F));
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        foreach (OFS[i])
            chk("reset", seen(OFS[i]), 32'h0);
        // Random drawing loads, one idle cycle apart, over every offset
        repeat (3)
            foreach (OFS[i])
            begin
                d = $urandom();
                i_draw_cmd_model.cmd_draw(OFS[i], d);
                chk("param", seen(OFS[i]), exp_field(OFS[i], d));
            end
        // Register-load to drawing-only offsets is refused
        foreach (OFS[i])
        begin
            prev = seen(OFS[i]);
            i_draw_cmd_model.cmd_reg(OFS[i], $urandom());
            chk("refused", 32'(reg_load_refused), 32'h1);
            chk("kept", seen(OFS[i]), prev);
        end
        // Key colour: register-load only, palette in low byte
        d = $urandom();
        i_draw_cmd_model.cmd_reg(12'h280, d);
        chk("refused", 32'(reg_load_refused), 32'h0);
        chk("key", 32'(transparent_key_color), {16'h0, d[15:0]});
        chk("palette", 32'(key_palette_code), {24'h0, d[7:0]});
        i_draw_cmd_model.cmd_draw(12'h280, ~d);
        chk("key", 32'(transparent_key_color), {16'h0, d[15:0]});
        prev = seen(12'h240);
        i_draw_cmd_model.host(1'b1, 8'h00, ~d);
        chk("cpu_rdata", cpu_rdata, 32'h0);
        chk("key", 32'(transparent_key_color), {16'h0, d[15:0]});
        chk("kept", seen(12'h240), prev);
        // Status word: corner queue counts first, then random states
        for (int i = 0; i < 24; i++)
        begin
            d = $urandom();
            {pixel_busy, setup_busy, setup_alt, geometry_busy} = d[3:0];
            qf = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : (i == 2) ? 6'h1F :
                 (i == 3) ? 6'h1E : d[9:4];
            queue_free = qf;
            read_chk(8'h00, exp_stat(1'b0));
            i_draw_cmd_model.host(1'b0, 8'h00, 32'h0);
            chk("reread", cpu_rdata, exp_stat(1'b0));
        end
        read_chk(8'h04, 32'h0);
        // Overflow: push into a full queue, flag stays afterwards
        queue_free = 6'h00;
        @(negedge clk_sys);
        queue_push = 1'b1;
        @(negedge clk_sys);
        queue_push = 1'b0;
        read_chk(8'h00, exp_stat(1'b1));
        queue_free = 6'h3F;
        read_chk(8'h00, exp_stat(1'b1));
        tally_and_finish();
    end
endmodule : draw_param_bank_tb_top

/* File: verilog/draw_param_bank.sv */
// Drawing engine parameter registers and geometry status read port.
// Assumes loads arrive as one-cycle strobes from the command processor,
// and host reads come from a simple request/acknowledge port.
`timescale 1ns/1ps
`include "draw_param_consts.svh"
module draw_param_bank #(
    parameter int QUEUE_STAGES = 63
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Parameter loads carried by drawing commands
    input  wire logic        draw_load,
    input  wire logic [11:0] draw_load_offset,
    input  wire logic [31:0] draw_load_data,
    // Register-load command
    input  wire logic        reg_load,
    input  wire logic [11:0] reg_load_offset,
    input  wire logic [31:0] reg_load_data,
    output logic             reg_load_refused,
    // Host access to the geometry register space
    input  wire logic        cpu_req,
    input  wire logic        cpu_write,
    input  wire logic [7:0]  cpu_addr,
    input  wire logic [31:0] cpu_wdata,
    output logic             cpu_ack,
    output logic [31:0]      cpu_rdata,
    // Live engine and queue state
    input  wire logic        pixel_busy,
    input  wire logic        setup_busy,
    input  wire logic        setup_alt,
    input  wire logic        geometry_busy,
    input  wire logic [5:0]  queue_free,
    input  wire logic        queue_push,
    // Parameters presented to the engines
    output logic [24:0]      blit_source_address,
    output logic [11:0]      blit_source_pitch,
    output logic [11:0]      blit_source_x_start,
    output logic [11:0]      blit_source_y_start,
    output logic [24:0]      blit_dest_address,
    output logic [11:0]      blit_dest_pitch,
    output logic [11:0]      blit_dest_x_start,
    output logic [11:0]      blit_dest_y_start,
    output logic [11:0]      blit_width,
    output logic [11:0]      blit_height,
    output logic [15:0]      transparent_key_color,
    output logic [7:0]       key_palette_code,
    output logic [11:0]      rect_left_x,
    output logic [11:0]      rect_top_y,
    output logic [11:0]      rect_width,
    output logic [11:0]      rect_height,
    output logic [11:0]      fast_line_v0_x,
    output logic [11:0]      fast_line_v0_y,
    output logic [11:0]      fast_line_v1_x,
    output logic [11:0]      fast_line_v1_y,
    output logic [11:0]      fast_tri_v0_x,
    output logic [11:0]      fast_tri_v0_y,
    output logic [11:0]      fast_tri_v1_x,
    output logic [11:0]      fast_tri_v1_y,
    output logic [11:0]      fast_tri_v2_x,
    output logic [11:0]      fast_tri_v2_y
);
    draw_param_pkg::param_regs_type r_q;
    draw_param_pkg::param_regs_type r_d;

    geo_status_if stat ();

    // Integer coordinate field; upper four bits dropped as zero
    function automatic logic [11:0] int_field(input logic [31:0] d);
        int_field = d[`INT_MSB:`INT_LSB];
    endfunction : int_field

    // Byte address field; bits above it are zero by definition
    function automatic logic [24:0] addr_field(input logic [31:0] d);
        addr_field = d[`ADDR_MSB:0];
    endfunction : addr_field

    // Status collector runs beside the bank on the same clock
    geo_status_collect #(
        .QUEUE_STAGES (QUEUE_STAGES)
    ) u_status (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .pixel_busy    (pixel_busy),
        .setup_busy    (setup_busy),
        .setup_alt     (setup_alt),
        .geometry_busy (geometry_busy),
        .queue_free    (queue_free),
        .queue_push    (queue_push),
        .stat          (stat.producer)
    );

    // Next state: drawing loads, key-colour load, host read answer
    always_comb
    begin
        r_d = r_q;
        r_d.cpu_ack = 1'b0;
        r_d.load_refused = 1'b0;
        // Drawing commands reach all but the key colour
        if (draw_load)
        begin
            case (draw_load_offset)
                `OFS_RECT_LEFT_X:    r_d.rect_x = int_field(draw_load_data);
                `OFS_RECT_TOP_Y:     r_d.rect_y = int_field(draw_load_data);
                `OFS_RECT_WIDTH:     r_d.rect_w = int_field(draw_load_data);
                `OFS_RECT_HEIGHT:    r_d.rect_h = int_field(draw_load_data);
                `OFS_BLIT_SRC_ADDR:
                    r_d.src_addr = addr_field(draw_load_data);
                `OFS_BLIT_SRC_PITCH:
                    r_d.src_pitch = int_field(draw_load_data);
                `OFS_BLIT_SRC_X:     r_d.src_x = int_field(draw_load_data);
                `OFS_BLIT_SRC_Y:     r_d.src_y = int_field(draw_load_data);
                `OFS_BLIT_DST_ADDR:
                    r_d.dst_addr = addr_field(draw_load_data);
                `OFS_BLIT_DST_PITCH:
                    r_d.dst_pitch = int_field(draw_load_data);
                `OFS_BLIT_DST_X:     r_d.dst_x = int_field(draw_load_data);
                `OFS_BLIT_DST_Y:     r_d.dst_y = int_field(draw_load_data);
                `OFS_BLIT_WIDTH:
                    r_d.blit_w = int_field(draw_load_data);
                `OFS_BLIT_HEIGHT:
                    r_d.blit_h = int_field(draw_load_data);
                `OFS_LINE_V0_X:
                    r_d.line_v0_x = int_field(draw_load_data);
                `OFS_LINE_V0_Y:
                    r_d.line_v0_y = int_field(draw_load_data);
                `OFS_LINE_V1_X:
                    r_d.line_v1_x = int_field(draw_load_data);
                `OFS_LINE_V1_Y:
                    r_d.line_v1_y = int_field(draw_load_data);
                `OFS_TRI_V0_X:
                    r_d.tri_v0_x = int_field(draw_load_data);
                `OFS_TRI_V0_Y:
                    r_d.tri_v0_y = int_field(draw_load_data);
                `OFS_TRI_V1_X:
                    r_d.tri_v1_x = int_field(draw_load_data);
                `OFS_TRI_V1_Y:
                    r_d.tri_v1_y = int_field(draw_load_data);
                `OFS_TRI_V2_X:
                    r_d.tri_v2_x = int_field(draw_load_data);
                `OFS_TRI_V2_Y:
                    r_d.tri_v2_y = int_field(draw_load_data);
                default: ;  // Key colour and unknown offsets: no effect
            endcase
        end
        // Register-load command reaches the key colour only
        if (reg_load)
        begin
            if (reg_load_offset == `OFS_KEY_COLOR)
                r_d.key_color = reg_load_data[`COLOR_MSB:0];
            else
                r_d.load_refused = 1'b1;
        end
        // Host sees only the status word; writes are dropped
        if (cpu_req)
        begin
            r_d.cpu_ack = 1'b1;
            if (!cpu_write && cpu_addr == `OFS_GEO_STATUS)
                r_d.cpu_rdata = stat.status_word;
            else
                r_d.cpu_rdata = 32'h0000_0000;
        end
    end

    // Parameters clear to zero so engines never see stale garbage
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    // Data outputs straight from the register copy
    assign blit_source_address   = r_q.src_addr;
    assign blit_source_pitch     = r_q.src_pitch;
    assign blit_source_x_start   = r_q.src_x;
    assign blit_source_y_start   = r_q.src_y;
    assign blit_dest_address     = r_q.dst_addr;
    assign blit_dest_pitch       = r_q.dst_pitch;
    assign blit_dest_x_start     = r_q.dst_x;
    assign blit_dest_y_start     = r_q.dst_y;
    assign blit_width            = r_q.blit_w;
    assign blit_height           = r_q.blit_h;
    assign transparent_key_color = r_q.key_color;
    assign key_palette_code      = r_q.key_color[7:0];
    assign rect_left_x           = r_q.rect_x;
    assign rect_top_y            = r_q.rect_y;
    assign rect_width            = r_q.rect_w;
    assign rect_height           = r_q.rect_h;
    assign fast_line_v0_x        = r_q.line_v0_x;
    assign fast_line_v0_y        = r_q.line_v0_y;
    assign fast_line_v1_x        = r_q.line_v1_x;
    assign fast_line_v1_y        = r_q.line_v1_y;
    assign fast_tri_v0_x         = r_q.tri_v0_x;
    assign fast_tri_v0_y         = r_q.tri_v0_y;
    assign fast_tri_v1_x         = r_q.tri_v1_x;
    assign fast_tri_v1_y         = r_q.tri_v1_y;
    assign fast_tri_v2_x         = r_q.tri_v2_x;
    assign fast_tri_v2_y         = r_q.tri_v2_y;
    assign cpu_ack               = r_q.cpu_ack;
    assign cpu_rdata             = r_q.cpu_rdata;
    assign reg_load_refused      = r_q.load_refused;

    // Key-colour load by the register-load command
    sequence s_key_load;
        reg_load && reg_load_offset == `OFS_KEY_COLOR;
    endsequence

    property p_key_load;
        @(posedge clk_sys) disable iff (rst)
        s_key_load |=> transparent_key_color ==
                       $past(reg_load_data[15:0]);
    endproperty
    a_key_load: assert property (p_key_load)
        else $error("key colour not taken from register load");

    property p_key_no_draw;
        @(posedge clk_sys) disable iff (rst)
        (draw_load && draw_load_offset == `OFS_KEY_COLOR && !reg_load)
        |=> $stable(transparent_key_color);
    endproperty
    a_key_no_draw: assert property (p_key_no_draw)
        else $error("drawing load changed key colour");

    property p_palette_low;
        @(posedge clk_sys) disable iff (rst)
        s_key_load |=> key_palette_code == $past(reg_load_data[7:0]);
    endproperty
    a_palette_low: assert property (p_palette_low)
        else $error("palette code not in low byte");

    property p_src_addr;
        @(posedge clk_sys) disable iff (rst)
        (draw_load && draw_load_offset == `OFS_BLIT_SRC_ADDR)
        |=> blit_source_address == $past(draw_load_data[24:0]);
    endproperty
    a_src_addr: assert property (p_src_addr)
        else $error("source address not loaded");

    property p_dst_addr;
        @(posedge clk_sys) disable iff (rst)
        (draw_load && draw_load_offset == `OFS_BLIT_DST_ADDR)
        |=> blit_dest_address == $past(draw_load_data[24:0]);
    endproperty
    a_dst_addr: assert property (p_dst_addr)
        else $error("destination address not loaded");

    property p_reg_load_blocked;
        @(posedge clk_sys) disable iff (rst)
        (reg_load && reg_load_offset == `OFS_BLIT_SRC_PITCH && !draw_load)
        |=> $stable(blit_source_pitch) && reg_load_refused;
    endproperty
    a_reg_load_blocked: assert property (p_reg_load_blocked)
        else $error("register load reached a blit register");

    property p_dst_pitch;
        @(posedge clk_sys) disable iff (rst)
        (draw_load && draw_load_offset == `OFS_BLIT_DST_PITCH)
        |=> blit_dest_pitch == $past(draw_load_data[27:16]);
    endproperty
    a_dst_pitch: assert property (p_dst_pitch)
        else $error("destination pitch wrong");

    property p_src_y;
        @(posedge clk_sys) disable iff (rst)
        (draw_load && draw_load_offset == `OFS_BLIT_SRC_Y)
        |=> blit_source_y_start == $past(draw_load_data[27:16]);
    endproperty
    a_src_y: assert property (p_src_y)
        else $error("source y origin wrong");

    property p_tri_blocked;
        @(posedge clk_sys) disable iff (rst)
        (reg_load && reg_load_offset == `OFS_TRI_V2_Y && !draw_load)
        |=> $stable(fast_tri_v2_y);
    endproperty
    a_tri_blocked: assert property (p_tri_blocked)
        else $error("register load reached a triangle vertex");

    property p_cpu_read;
        @(posedge clk_sys) disable iff (rst)
        (cpu_req && !cpu_write && cpu_addr == `OFS_GEO_STATUS)
        |=> cpu_ack && cpu_rdata == $past(stat.status_word);
    endproperty
    a_cpu_read: assert property (p_cpu_read)
        else $error("status read answer wrong");

    // Three more drawing loads land on outputs: dest x, blit width, line v1 y
    sequence s_dx_load;
        draw_load && draw_load_offset == `OFS_BLIT_DST_X;
    endsequence

    property p_dst_x;
        @(posedge clk_sys) disable iff (rst)
        s_dx_load |=> blit_dest_x_start ==
            $past(draw_load_data[27:16]);
    endproperty
    a_dst_x: assert property (p_dst_x)
        else $error("dest x origin wrong");

    property p_blit_w;
        @(posedge clk_sys) disable iff (rst)
        draw_load &&
        draw_load_offset == `OFS_BLIT_WIDTH
        |=> blit_width ==
            $past(draw_load_data[27:16]);
    endproperty
    a_blit_w: assert property (p_blit_w)
        else $error("blit width wrong");

    property p_line_v1_y;
        @(posedge clk_sys) disable iff (rst)
        draw_load &&
        draw_load_offset == `OFS_LINE_V1_Y
        |=> fast_line_v1_y ==
            $past(draw_load_data[27:16]);
    endproperty
    a_line_v1_y: assert property (p_line_v1_y)
        else $error("line vertex wrong");
endmodule : draw_param_bank

/* File: verilog/draw_param_consts.svh */
// Offsets, field positions, reset values and codes of the drawing
// parameter bank and the geometry status word.
// Assumes offsets are byte offsets from the drawing or geometry base.
`ifndef DRAW_PARAM_CONSTS_SVH
`define DRAW_PARAM_CONSTS_SVH

// Drawing-side parameter offsets
`define OFS_RECT_LEFT_X       12'h200
`define OFS_RECT_TOP_Y        12'h204
`define OFS_RECT_WIDTH        12'h208
`define OFS_RECT_HEIGHT       12'h20C
`define OFS_BLIT_SRC_ADDR     12'h240
`define OFS_BLIT_SRC_PITCH    12'h244
`define OFS_BLIT_SRC_X        12'h248
`define OFS_BLIT_SRC_Y        12'h24C
`define OFS_BLIT_DST_ADDR     12'h250
`define OFS_BLIT_DST_PITCH    12'h254
`define OFS_BLIT_DST_X        12'h258
`define OFS_BLIT_DST_Y        12'h25C
`define OFS_BLIT_WIDTH        12'h260
`define OFS_BLIT_HEIGHT       12'h264
`define OFS_KEY_COLOR         12'h280
`define OFS_LINE_V0_X         12'h540
`define OFS_LINE_V0_Y         12'h544
`define OFS_LINE_V1_X         12'h548
`define OFS_LINE_V1_Y         12'h54C
`define OFS_TRI_V0_X          12'h580
`define OFS_TRI_V0_Y          12'h584
`define OFS_TRI_V1_X          12'h588
`define OFS_TRI_V1_Y          12'h58C
`define OFS_TRI_V2_X          12'h590
`define OFS_TRI_V2_Y          12'h594
// Geometry-side offset
`define OFS_GEO_STATUS        8'h00

// Field positions
`define INT_MSB               27
`define INT_LSB               16
`define ADDR_MSB              24
`define COLOR_MSB             15

// Status word
`define GEO_STATUS_RESET      32'h000F_9000
`define ENG_IDLE              2'h0
`define ENG_BUSY              2'h1
`define SETUP_BUSY_ALT        2'h2

`endif

/* File: verilog/draw_param_pkg.sv */
// Types shared by the drawing parameter bank and its status collector.
// Assumes the constants header is included by the users.
package draw_param_pkg;

    typedef struct packed {
        logic [24:0] src_addr;
        logic [11:0] src_pitch;
        logic [11:0] src_x;
        logic [11:0] src_y;
        logic [24:0] dst_addr;
        logic [11:0] dst_pitch;
        logic [11:0] dst_x;
        logic [11:0] dst_y;
        logic [11:0] blit_w;
        logic [11:0] blit_h;
        logic [15:0] key_color;
        logic [11:0] rect_x;
        logic [11:0] rect_y;
        logic [11:0] rect_w;
        logic [11:0] rect_h;
        logic [11:0] line_v0_x;
        logic [11:0] line_v0_y;
        logic [11:0] line_v1_x;
        logic [11:0] line_v1_y;
        logic [11:0] tri_v0_x;
        logic [11:0] tri_v0_y;
        logic [11:0] tri_v1_x;
        logic [11:0] tri_v1_y;
        logic [11:0] tri_v2_x;
        logic [11:0] tri_v2_y;
        logic        cpu_ack;
        logic [31:0] cpu_rdata;
        logic        load_refused;
    } param_regs_type;

    typedef struct packed {
        logic [31:0] word;
        logic        overrun;
    } status_state_type;

endpackage : draw_param_pkg

/* File: verilog/geo_status_collect.sv */
// Builds the geometry status word from live engine and queue state.
// Assumes all inputs come from logic on clk_sys.
`timescale 1ns/1ps
`include "draw_param_consts.svh"
module geo_status_collect #(
    parameter int QUEUE_STAGES = 63
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       pixel_busy,
    input  wire logic       setup_busy,
    input  wire logic       setup_alt,
    input  wire logic       geometry_busy,
    input  wire logic [5:0] queue_free,
    input  wire logic       queue_push,
    geo_status_if.producer  stat
);
    draw_param_pkg::status_state_type s_q;
    draw_param_pkg::status_state_type s_d;

    // Word rebuilt every cycle so the engine fields track live state
    always_comb
    begin
        s_d = s_q;
        s_d.overrun = s_q.overrun | (queue_push && queue_free == 6'h00);
        s_d.word = 32'h0000_0000;
        s_d.word[1:0] = pixel_busy ? `ENG_BUSY : `ENG_IDLE;
        s_d.word[5:4] = !setup_busy ? `ENG_IDLE :
                        (setup_alt ? `SETUP_BUSY_ALT : `ENG_BUSY);
        s_d.word[9:8] = geometry_busy ? `ENG_BUSY : `ENG_IDLE;
        s_d.word[12] = (queue_free == 6'(QUEUE_STAGES));
        s_d.word[13] = (queue_free == 6'h00);
        s_d.word[14] = (queue_free < 6'(QUEUE_STAGES / 2));
        s_d.word[20:15] = queue_free;
        s_d.word[24] = s_d.overrun;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_q.word    <= `GEO_STATUS_RESET;
            s_q.overrun <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign stat.status_word = s_q.word;

    property p_pixel_state;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> s_q.word[1:0] == ($past(pixel_busy) ? 2'h1 : 2'h0);
    endproperty
    a_pixel_state: assert property (p_pixel_state)
        else $error("pixel engine field wrong");

    property p_setup_state;
        @(posedge clk_sys) disable iff (rst)
        setup_busy |=> s_q.word[5:4] != 2'h0 && s_q.word[5:4] != 2'h3;
    endproperty
    a_setup_state: assert property (p_setup_state)
        else $error("setup engine field wrong");

    property p_overrun_sticky;
        @(posedge clk_sys) disable iff (rst)
        (queue_push && queue_free == 6'h00) |=> s_q.word[24] [*8];
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky)
        else $error("overrun flag not held");

    property p_full_empty;
        @(posedge clk_sys) disable iff (rst)
        (queue_free == 6'h00) |=> s_q.word[13] && !s_q.word[12];
    endproperty
    a_full_empty: assert property (p_full_empty)
        else $error("queue full or empty flag wrong");
endmodule : geo_status_collect

/* File: verilog/geo_status_if.sv */
// Carries the registered geometry status word to the register bank.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface geo_status_if;
    logic [31:0] status_word;

    modport producer (output status_word);
    modport consumer (input  status_word);
endinterface : geo_status_if
